// ---- inc/pmtt_pkg.sv ----
// package of constants and types for the pci master tenure timer
package pmtt_pkg;
    localparam int unsigned LAT_W         = 8;
    localparam logic [7:0]  LAT_RESET     = 8'h00;
    localparam logic [7:0]  LAT_GRAN_MASK = 8'hf8;
    localparam logic [7:0]  FIRST_LIMIT   = 8'h10;
    localparam logic [7:0]  NEXT_LIMIT    = 8'h08;
    localparam logic [1:0]  ARB_DELAY     = 2'h2;

    typedef enum logic [3:0] {
        PMTT_IDLE  = 4'h1,
        PMTT_WAIT  = 4'h2,
        PMTT_ADDR  = 4'h4,
        PMTT_DATA  = 4'h8
    } pmtt_state_e;
endpackage

// ---- inc/pmtt_if.sv ----
// bus signals between the tenure controlling master and the arbiter/target end
`timescale 1ns/100ps
interface pmtt_if;
    logic req;
    logic gnt;
    logic frame;
    logic irdy;
    logic trdy;
    logic bus_busy;

    modport master
    (
        output req,
        output frame,
        output irdy,
        input  gnt,
        input  trdy,
        input  bus_busy
    );
    modport system
    (
        input  req,
        input  frame,
        input  irdy,
        output gnt,
        output trdy,
        output bus_busy
    );
endinterface // pmtt_if

// ---- design/pmtt_master.sv ----
// master end: latency timer and bus tenure control
`timescale 1ns/100ps
module pmtt_master
(
    input  wire logic       clk,
    input  wire logic       rstn,
    pmtt_if.master          bus,
    input  wire logic       lat_we,
    input  wire logic [7:0] lat_wdata,
    input  wire logic       xfer_start,
    input  wire logic [7:0] xfer_len,
    output logic      [7:0] lat_value,
    output logic            lat_expired,
    output logic            xfer_busy,
    output logic            xfer_done,
    output logic            phase_ack,
    output logic            phase_late
);
    pmtt_pkg::pmtt_state_e state_q, state_d;
    logic [7:0] lat_q, lat_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] left_q, left_d;
    logic [7:0] wait_q, wait_d;
    logic       first_q, first_d;
    logic       pend_q, pend_d;
    logic       done_q, done_d;
    logic       late_q, late_d;
    logic       last;
    logic       stop;

    assign last = (left_q == 8'h01);
    // expired timer only ends tenure when grant is gone
    assign stop = (cnt_q == 8'h00) && !bus.gnt;

    always_comb
    begin
        state_d = state_q;
        lat_d   = lat_q;
        cnt_d   = cnt_q;
        left_d  = left_q;
        wait_d  = wait_q;
        first_d = first_q;
        pend_d  = pend_q;
        done_d  = 1'b0;
        late_d  = 1'b0;
        if (lat_we)
            lat_d = lat_wdata & pmtt_pkg::LAT_GRAN_MASK;
        if (state_q != pmtt_pkg::PMTT_IDLE && cnt_q != 8'h00)
            cnt_d = cnt_q - 8'h01;
        case (state_q)
            pmtt_pkg::PMTT_IDLE:
            begin
                if (xfer_start && xfer_len != 8'h00)
                begin
                    left_d  = xfer_len;
                    state_d = pmtt_pkg::PMTT_WAIT;
                end
            end
            pmtt_pkg::PMTT_WAIT:
            begin
                // grant alone is not enough, bus may still be in use
                if (bus.gnt && !bus.bus_busy)
                begin
                    cnt_d   = lat_q;
                    state_d = pmtt_pkg::PMTT_ADDR;
                end
            end
            pmtt_pkg::PMTT_ADDR:
            begin
                first_d = 1'b1;
                wait_d  = 8'h00;
                state_d = pmtt_pkg::PMTT_DATA;
            end
            pmtt_pkg::PMTT_DATA:
            begin
                wait_d = wait_q + 8'h01;
                if (wait_q >= (first_q ? pmtt_pkg::FIRST_LIMIT
                                       : pmtt_pkg::NEXT_LIMIT) - 8'h01 && !bus.trdy)
                    late_d = 1'b1;
                if (bus.trdy)
                begin
                    wait_d  = 8'h00;
                    first_d = 1'b0;
                    left_d  = left_q - 8'h01;
                    if (last)
                    begin
                        done_d  = 1'b1;
                        state_d = pmtt_pkg::PMTT_IDLE;
                    end
                    else if (stop)
                    begin
                        // remainder waits for a fresh tenure
                        state_d = pmtt_pkg::PMTT_WAIT;
                    end
                end
            end
            default:
                state_d = pmtt_pkg::PMTT_IDLE;
        endcase
        // final phase drops frame: last dword, or tenure ending on expiry when stop is set before that phase's trdy
        pend_d = (state_d == pmtt_pkg::PMTT_DATA) && last_next(left_d, stop);
    end

    function automatic logic last_next(logic [7:0] l, logic st);
        last_next = (l == 8'h01) || st;
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= pmtt_pkg::PMTT_IDLE;
            lat_q   <= pmtt_pkg::LAT_RESET;
            cnt_q   <= 8'h00;
            left_q  <= 8'h00;
            wait_q  <= 8'h00;
            first_q <= 1'b0;
            pend_q  <= 1'b0;
            done_q  <= 1'b0;
            late_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            lat_q   <= lat_d;
            cnt_q   <= cnt_d;
            left_q  <= left_d;
            wait_q  <= wait_d;
            first_q <= first_d;
            pend_q  <= pend_d;
            done_q  <= done_d;
            late_q  <= late_d;
        end
    end

    assign bus.req   = (state_q == pmtt_pkg::PMTT_WAIT);
    // frame drops on the final phase unless stop rises with its trdy, irdy holds until target ready
    assign bus.frame = (state_q == pmtt_pkg::PMTT_ADDR) ||
                       (state_q == pmtt_pkg::PMTT_DATA && !pend_q);
    assign bus.irdy  = (state_q == pmtt_pkg::PMTT_DATA);
    assign lat_value   = lat_q;
    assign lat_expired = (cnt_q == 8'h00) && (state_q == pmtt_pkg::PMTT_DATA);
    assign xfer_busy   = (state_q != pmtt_pkg::PMTT_IDLE);
    assign xfer_done   = done_q;
    assign phase_ack   = (state_q == pmtt_pkg::PMTT_DATA) && bus.trdy;
    assign phase_late  = late_q;
endmodule // pmtt_master

// ---- design/pmtt_system.sv ----
// far end: arbiter for one master plus a simple target
`timescale 1ns/100ps
module pmtt_system
(
    input  wire logic       clk,
    input  wire logic       rstn,
    pmtt_if.system          bus,
    input  wire logic       grant_en,
    input  wire logic       other_busy,
    input  wire logic [3:0] trdy_delay,
    output logic            granted
);
    logic [1:0] arb_q, arb_d;
    logic [3:0] dly_q, dly_d;
    logic       gnt_q, gnt_d;
    logic       busy_q, busy_d;

    always_comb
    begin
        arb_d  = arb_q;
        dly_d  = dly_q;
        gnt_d  = gnt_q;
        // owner frees the bus, bus_busy clears one clock later
        busy_d = other_busy;
        if (bus.req && grant_en && !gnt_q)
        begin
            arb_d = arb_q + 2'h1;
            if (arb_q + 2'h1 >= pmtt_pkg::ARB_DELAY - 2'h1)
                gnt_d = 1'b1;
        end
        else if (!bus.req || !grant_en)
        begin
            arb_d = 2'h0;
            if (!bus.frame)
                gnt_d = bus.req && grant_en;
            else
                gnt_d = grant_en;
        end
        if (bus.irdy && dly_q < trdy_delay)
            dly_d = dly_q + 4'h1;
        else
            dly_d = 4'h0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            arb_q  <= 2'h0;
            dly_q  <= 4'h0;
            gnt_q  <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            arb_q  <= arb_d;
            dly_q  <= dly_d;
            gnt_q  <= gnt_d;
            busy_q <= busy_d;
        end
    end

    assign bus.gnt      = gnt_q;
    assign bus.bus_busy = busy_q;
    // delay is 4 bits so first phase always meets its limit
    assign bus.trdy     = bus.irdy && (dly_q >= trdy_delay);
    assign granted      = gnt_q;
endmodule // pmtt_system

// ---- dv/pmtt_checker.sv ----
// concurrent checks on the tenure bus between master and system ends
`timescale 1ns/100ps
module pmtt_checker
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic gnt,
    input wire logic frame,
    input wire logic irdy,
    input wire logic trdy,
    input wire logic bus_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_reset_idle: assert property ($rose(rstn) |-> !req && !frame && !irdy)
        else $error("bus active after reset");
    chk_start_free: assert property ($rose(frame) |-> $past(gnt) && !$past(bus_busy))
        else $error("access started without free bus");
    chk_addr_then_data: assert property ($rose(frame) |=> irdy)
        else $error("no data phase after address");
    chk_first_phase: assert property ($rose(frame) |-> ##[1:16] trdy)
        else $error("first phase too slow");
    chk_next_phase: assert property (trdy && frame && gnt |-> ##[1:8] trdy)
        else $error("later phase too slow");
    chk_ready_ends: assert property ($fell(irdy) |-> $past(trdy))
        else $error("data state left without ready");
    chk_burst_held: assert property (irdy && trdy && frame && gnt |=> irdy)
        else $error("burst dropped while granted");
    chk_req_holds: assert property ($fell(req) |-> $past(gnt))
        else $error("request dropped before grant");
    // main scenarios reached
    cover property ($rose(frame));
    cover property (trdy && frame && gnt);
    cover property (irdy && !gnt);
endmodule // pmtt_checker

// ---- dv/tb.sv ----
// testbench joining master and system ends over the tenure bus
`timescale 1ns/100ps
module tb;
    logic       clk        = 1'b0;
    logic       rstn       = 1'b0;
    logic       lat_we     = 1'b0;
    logic [7:0] lat_wdata  = 8'h00;
    logic       xfer_start = 1'b0;
    logic [7:0] xfer_len   = 8'h00;
    logic       grant_en   = 1'b1;
    logic       other_busy = 1'b0;
    logic [3:0] trdy_delay = 4'h0;
    logic [7:0] lat_value;
    logic       xfer_done;
    logic       phase_ack;
    logic       phase_late;
    logic       lat_expired;
    logic       xfer_busy;
    logic       granted;
    logic       f_q        = 1'b0;
    int         err_count  = 0;
    int         tests_run  = 0;
    int         n_ack      = 0;
    int         n_ten      = 0;
    int         n_late     = 0;
    pmtt_if bus ();
    pmtt_master i_pmtt_master (.clk(clk), .rstn(rstn), .bus(bus), .lat_we(lat_we),
        .lat_wdata(lat_wdata), .xfer_start(xfer_start), .xfer_len(xfer_len),
        .lat_value(lat_value), .lat_expired(lat_expired), .xfer_busy(xfer_busy),
        .xfer_done(xfer_done), .phase_ack(phase_ack), .phase_late(phase_late));
    pmtt_system i_pmtt_system (.clk(clk), .rstn(rstn), .bus(bus), .grant_en(grant_en),
        .other_busy(other_busy), .trdy_delay(trdy_delay), .granted(granted));
    pmtt_checker i_pmtt_checker (.clk(clk), .rstn(rstn), .req(bus.req), .gnt(bus.gnt),
        .frame(bus.frame), .irdy(bus.irdy), .trdy(bus.trdy), .bus_busy(bus.bus_busy));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // tenure and phase counts, seen at the sampling edge
    always @(posedge clk)
    begin
        if (phase_ack === 1'b1) n_ack++;
        if (phase_late === 1'b1) n_late++;
        if (bus.frame === 1'b1 && f_q !== 1'b1) n_ten++;
        f_q = bus.frame;
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic set_lat(logic [7:0] v);
        @(negedge clk);
        lat_wdata = v;
        lat_we = 1'b1;
        @(negedge clk);
        lat_we = 1'b0;
    endtask
    task automatic xfer(logic [7:0] len, logic [3:0] dly);
        int i;
        @(negedge clk);
        n_ack = 0;
        n_ten = 0;
        n_late = 0;
        trdy_delay = dly;
        xfer_len = len;
        xfer_start = 1'b1;
        @(negedge clk);
        xfer_start = 1'b0;
        for (i = 0; i < 400 && xfer_done !== 1'b1; i++)
            @(negedge clk);
        check("xfer_done", {7'h00, xfer_done}, 8'h01);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        check("lat_value", lat_value, 8'h00);
        set_lat(8'h2f);
        check("lat_value", lat_value, 8'h28);
        set_lat(8'h07);
        check("lat_value", lat_value, 8'h00);
        // slowest legal target on a single transfer
        xfer(8'h01, 4'hf);
        check("single phases", n_ack[7:0], 8'h01);
        check("late phases", n_late[7:0], 8'h00);
        // expired timer but grant held: one tenure
        xfer(8'h04, 4'h7);
        check("burst phases", n_ack[7:0], 8'h04);
        check("burst tenures", n_ten[7:0], 8'h01);
        other_busy = 1'b1;
        fork
            xfer(8'h02, 4'h1);
            begin
                repeat (12) @(negedge clk);
                check("frame while busy", {7'h00, bus.frame}, 8'h00);
                check("acks while busy", n_ack[7:0], 8'h00);
                check("grant while busy", {7'h00, granted}, 8'h01);
                other_busy = 1'b0;
            end
        join
        check("busy phases", n_ack[7:0], 8'h02);
        // grant pulled mid burst: tenure ends, remainder rerequests
        fork
            xfer(8'h08, 4'h2);
            begin
                repeat (9) @(negedge clk);
                grant_en = 1'b0;
                repeat (8) @(negedge clk);
                grant_en = 1'b1;
            end
        join
        check("split phases", n_ack[7:0], 8'h08);
        check("split tenures", n_ten[7:0], 8'h02);
        // timer still running when grant is pulled: tenure lasts to expiry
        set_lat(8'h0c);
        check("lat_value", lat_value, 8'h08);
        fork
            xfer(8'h08, 4'h2);
            begin
                repeat (5) @(negedge clk);
                grant_en = 1'b0;
                repeat (6) @(negedge clk);
                check("lat_expired early", {7'h00, lat_expired}, 8'h00);
                @(negedge clk);
                check("lat_expired", {7'h00, lat_expired}, 8'h01);
                repeat (5) @(negedge clk);
                check("timed phases", n_ack[7:0], 8'h03);
                check("xfer_busy", {7'h00, xfer_busy}, 8'h01);
                check("granted", {7'h00, granted}, 8'h00);
                repeat (4) @(negedge clk);
                grant_en = 1'b1;
            end
        join
        check("timed phases", n_ack[7:0], 8'h08);
        check("timed tenures", n_ten[7:0], 8'h02);
        // reset in mid-run clears the setting
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check("lat_value", lat_value, 8'h00);
        check("xfer_busy", {7'h00, xfer_busy}, 8'h00);
        xfer(8'h01, 4'h0);
        check("after reset phases", n_ack[7:0], 8'h01);
        stop_test();
    end
    // long enough for every transfer above at their slowest
    initial
    begin
        #(100 * 4000);
        err_count++;
        stop_test();
    end
endmodule // tb
